// file: core/mow_decoder.sv
// Decoder for selector load, option load and port control targeting
//
// Operation
// - Literal form loads selector low nibble
// - Literal form keeps selector upper nibble
// - Accumulator form loads selector, accumulator kept
// - Accumulator form writes all eight bits
// - Whole selector picks control register
// - Whole selector is the target pointer
// - 1Dh level, 1Eh pullup, 1Fh direction
// - Option load copies accumulator, accumulator kept
// - Port field 5 to 9 selects A to E
// - Selector decides read, write or exchange
//
// The address-and-strobe port and the register addresses were decided locally.
module mow_decoder
    import mow_pkg::*;
(
    input  wire logic              clk,           // Core clock
    input  wire logic              reset,         // Sync reset, high
    input  wire logic              ce,            // Clock enable
    input  wire logic              instr_valid,   // Opcode present
    input  wire logic [OP_W-1:0]   instr_op,      // Opcode word
    input  wire logic [DATA_W-1:0] acc_in,        // Accumulator value
    input  wire logic [ADDR_W-1:0] reg_addr,      // Register index
    input  wire logic [DATA_W-1:0] reg_wdata,     // Register write data
    input  wire logic              reg_wr,        // Write strobe
    input  wire logic              reg_rd,        // Read strobe
    output logic      [DATA_W-1:0] reg_rdata,     // Read data, next cycle
    output logic      [DATA_W-1:0] selector,      // Selector register
    output logic      [DATA_W-1:0] option,        // Counter option reg
    output logic                   instr_done,    // Instruction retired
    output logic                   flags_we,      // Status flag write
    output logic                   xfr_valid,     // Port transfer issued
    output logic      [2:0]        xfr_port,      // Port 0=A .. 4=E
    output logic      [DATA_W-1:0] xfr_pointer,   // Target pointer
    output mow_kind_t              xfr_kind,      // Control reg kind
    output mow_access_t            xfr_access     // Transfer access
);
    logic [DATA_W-1:0] selector_q;
    logic [DATA_W-1:0] option_q;
    logic [DATA_W-1:0] rdata_q;
    logic              done_q;
    logic              flags_we_q;
    logic              xfr_valid_q;
    logic [2:0]        xfr_port_q;
    logic [DATA_W-1:0] xfr_pointer_q;
    mow_kind_t         xfr_kind_q;
    mow_access_t       xfr_access_q;

    logic              dec_lit_sel;
    logic              dec_acc_sel;
    logic              dec_acc_opt;
    logic              dec_xfr;
    mow_kind_t         kind_d;
    mow_access_t       access_d;

    assign dec_lit_sel = instr_valid && instr_op[11:4] == OP_LIT_SEL_HI;
    assign dec_acc_sel = instr_valid && instr_op == OP_ACC_SEL;
    assign dec_acc_opt = instr_valid && instr_op == OP_ACC_OPT;
    assign dec_xfr     = instr_valid && instr_op[11:4] == OP_PORT_XFR_HI
                         && instr_op[3:0] >= PORT_FIRST
                         && instr_op[3:0] <= PORT_LAST;

    // Kind follows the whole pointer; other values left to later logic
    always_comb begin
        unique case (selector_q)
            SEL_LEVEL:     kind_d = MOW_KIND_LEVEL;
            SEL_PULLUP:    kind_d = MOW_KIND_PULLUP;
            SEL_DIRECTION: kind_d = MOW_KIND_DIRECTION;
            default:       kind_d = MOW_KIND_OTHER;
        endcase
    end

    always_comb begin
        if (selector_q[7:4] == ACC_WRITE_HI) begin
            access_d = MOW_ACC_WRITE;
        end else if (selector_q[7:4] == ACC_XCHG_HI) begin
            access_d = MOW_ACC_XCHG;
        end else begin
            access_d = MOW_ACC_READ;
        end
    end

    // Instruction beats a same-cycle software write: the program owns it
    always_ff @(posedge clk) begin
        if (reset) begin
            selector_q <= SELECTOR_RST;
        end else if (ce) begin
            if (dec_lit_sel) begin
                selector_q[3:0] <= instr_op[3:0];
            end else if (dec_acc_sel) begin
                selector_q <= acc_in;
            end else if (reg_wr && reg_addr == REG_SELECTOR) begin
                selector_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            option_q <= OPTION_RST;
        end else if (ce) begin
            if (dec_acc_opt) begin
                option_q <= acc_in;
            end else if (reg_wr && reg_addr == REG_OPTION) begin
                option_q <= reg_wdata;
            end
        end
    end

    // Accumulator is input only, so it can never be disturbed here
    always_ff @(posedge clk) begin
        if (reset) begin
            done_q     <= 1'b0;
            flags_we_q <= 1'b0;
        end else if (ce) begin
            done_q     <= dec_lit_sel | dec_acc_sel | dec_acc_opt;
            flags_we_q <= 1'b0;
        end
    end

    // Transfer sees the selector before any same-cycle update
    always_ff @(posedge clk) begin
        if (reset) begin
            xfr_valid_q   <= 1'b0;
            xfr_port_q    <= 3'h0;
            xfr_pointer_q <= SELECTOR_RST;
            xfr_kind_q    <= MOW_KIND_OTHER;
            xfr_access_q  <= MOW_ACC_READ;
        end else if (ce) begin
            xfr_valid_q <= dec_xfr;
            if (dec_xfr) begin
                xfr_port_q    <= 3'(instr_op[3:0] - PORT_FIRST);
                xfr_pointer_q <= selector_q;
                xfr_kind_q    <= kind_d;
                xfr_access_q  <= access_d;
            end
        end
    end

    // Read data stand one cycle only; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (ce) begin
            rdata_q <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    REG_SELECTOR: rdata_q <= selector_q;
                    REG_OPTION:   rdata_q <= option_q;
                    REG_LAST_XFR: rdata_q <= {1'b0, xfr_access_q,
                                              xfr_kind_q, xfr_port_q};
                    default:      rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata   = rdata_q;
    assign selector    = selector_q;
    assign option      = option_q;
    assign instr_done  = done_q;
    assign flags_we    = flags_we_q;
    assign xfr_valid   = xfr_valid_q;
    assign xfr_port    = xfr_port_q;
    assign xfr_pointer = xfr_pointer_q;
    assign xfr_kind    = xfr_kind_q;
    assign xfr_access  = xfr_access_q;
endmodule

// file: core/mow_pkg.sv
// Constants and types for the selector and option write decoder
package mow_pkg;
    localparam int          OP_W           = 12;
    localparam int          DATA_W         = 8;
    localparam int          ADDR_W         = 4;

    // Opcode patterns
    localparam logic [7:0]  OP_LIT_SEL_HI  = 8'h05;   // 0000 0101 kkkk
    localparam logic [11:0] OP_ACC_SEL     = 12'h043; // 0000 0100 0011
    localparam logic [11:0] OP_ACC_OPT     = 12'h002; // 0000 0000 0010
    localparam logic [7:0]  OP_PORT_XFR_HI = 8'h00;   // 0000 0000 ffff
    localparam logic [3:0]  PORT_FIRST     = 4'h5;
    localparam logic [3:0]  PORT_LAST      = 4'h9;

    // Selector values that name control register kinds
    localparam logic [7:0]  SEL_LEVEL      = 8'h1d;
    localparam logic [7:0]  SEL_PULLUP     = 8'h1e;
    localparam logic [7:0]  SEL_DIRECTION  = 8'h1f;

    // Upper selector nibble to access type
    localparam logic [3:0]  ACC_WRITE_HI   = 4'h1;
    localparam logic [3:0]  ACC_XCHG_HI    = 4'h0;

    // Register word indices
    localparam logic [3:0]  REG_SELECTOR   = 4'h0;
    localparam logic [3:0]  REG_OPTION     = 4'h1;
    localparam logic [3:0]  REG_LAST_XFR   = 4'h2;

    // Reset values
    localparam logic [7:0]  SELECTOR_RST   = 8'h00;
    localparam logic [7:0]  OPTION_RST     = 8'h00;

    typedef enum logic [1:0] {
        MOW_KIND_OTHER,
        MOW_KIND_LEVEL,
        MOW_KIND_PULLUP,
        MOW_KIND_DIRECTION
    } mow_kind_t;

    typedef enum logic [1:0] {
        MOW_ACC_READ,
        MOW_ACC_WRITE,
        MOW_ACC_XCHG
    } mow_access_t;
endpackage

// file: tb/mow_checker.sv
// Assertions on the selector and option write decoder ports
module mow_checker
    import mow_pkg::*;
(
    input wire logic              clk,         // Core clock
    input wire logic              reset,       // Sync reset
    input wire logic              ce,          // Clock enable
    input wire logic              instr_valid, // Opcode present
    input wire logic [OP_W-1:0]   instr_op,    // Opcode word
    input wire logic [DATA_W-1:0] acc_in,      // Accumulator
    input wire logic [DATA_W-1:0] selector,    // Selector reg
    input wire logic [DATA_W-1:0] option,      // Option reg
    input wire logic              instr_done,  // Retired pulse
    input wire logic              flags_we,    // Flag write
    input wire logic              xfr_valid,   // Transfer pulse
    input wire logic [2:0]        xfr_port,    // Port index
    input wire logic [DATA_W-1:0] xfr_pointer  // Target pointer
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_lit;
        ce && instr_valid && instr_op[11:4] == OP_LIT_SEL_HI;
    endsequence
    sequence s_asel;
        ce && instr_valid && instr_op == OP_ACC_SEL;
    endsequence
    sequence s_aopt;
        ce && instr_valid && instr_op == OP_ACC_OPT;
    endsequence
    // Port field outside 5..9 is not a transfer
    sequence s_xfr;
        ce && instr_valid && instr_op[11:4] == OP_PORT_XFR_HI
            && instr_op[3:0] >= PORT_FIRST && instr_op[3:0] <= PORT_LAST;
    endsequence
    a_lit_low_load: assert property (
        s_lit |=> selector[3:0] == $past(instr_op[3:0]))
        else $error("literal nibble lost");
    a_lit_high_keep: assert property (
        s_lit |=> selector[7:4] == $past(selector[7:4]))
        else $error("upper nibble changed");
    a_acc_sel_load: assert property (
        s_asel |=> selector == $past(acc_in))
        else $error("selector load wrong");
    a_acc_opt_load: assert property (
        s_aopt |=> option == $past(acc_in))
        else $error("option load wrong");
    a_done_pulse: assert property (
        (s_lit or s_asel or s_aopt) |=> instr_done)
        else $error("no retire pulse");
    a_flags_quiet: assert property (
        !flags_we)
        else $error("flag write seen");
    a_xfr_pointer: assert property (
        s_xfr |=> xfr_valid && xfr_pointer == $past(selector))
        else $error("pointer wrong");
    a_xfr_port: assert property (
        s_xfr |=> xfr_port == 3'($past(instr_op[3:0]) - PORT_FIRST))
        else $error("port wrong");
endmodule

bind mow_decoder mow_checker u_chk (.clk, .reset, .ce, .instr_valid,
    .instr_op, .acc_in, .selector, .option, .instr_done, .flags_we,
    .xfr_valid, .xfr_port, .xfr_pointer);

// file: tb/mow_decoder_test.sv
// Self-checking bench for the selector and option write decoder
module mode_option_write_decode_test
    import mow_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, reset = 1, ce = 1, instr_valid = 0;
    logic reg_wr = 0, reg_rd = 0;
    logic [OP_W-1:0]   instr_op = '0;
    logic [DATA_W-1:0] acc_in = '0, reg_wdata = '0, sel;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_rdata, selector, option, xfr_pointer;
    logic              instr_done, flags_we, xfr_valid;
    logic [2:0]        xfr_port;
    mow_kind_t         xfr_kind;
    mow_access_t       xfr_access;
    int                n_errors = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    mow_decoder dut (.clk, .reset, .ce, .instr_valid, .instr_op, .acc_in,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .selector,
        .option, .instr_done, .flags_we, .xfr_valid, .xfr_port,
        .xfr_pointer, .xfr_kind, .xfr_access);
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic exec(logic [11:0] op, logic [7:0] a);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        acc_in <= a;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rw(logic wr, logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!wr) chk(reg_rdata, d);
    endtask
    task automatic summarize();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        exec(OP_ACC_SEL, 8'ha7);
        chk(selector, 8'ha7);
        chk({7'h0, instr_done}, 8'h01);
        exec({OP_LIT_SEL_HI, 4'h2}, 8'h00);
        chk(selector, 8'ha2);
        exec(OP_ACC_OPT, 8'h3f);
        chk(option, 8'h3f);
        chk({7'h0, flags_we}, 8'h00);
        @(posedge clk);
        ce <= 1'b0;
        exec(OP_ACC_OPT, 8'h55);
        chk(option, 8'h3f);
        @(posedge clk);
        ce <= 1'b1;
        // Last pass uses upper nibble 0 for exchange
        for (int p = 0; p < 6; p++) begin
            sel = (p == 5) ? 8'h08 : 8'h1d + 8'(p);
            exec(OP_ACC_SEL, sel);
            exec(12'(5 + p % 5), 8'h00);
            chk({7'h0, xfr_valid}, 8'h01);
            chk({5'h0, xfr_port}, 8'(p % 5));
            chk(xfr_pointer, sel);
            chk({6'h0, xfr_kind}, 8'(p < 3 ? p + 1 : 0));
            chk({6'h0, xfr_access}, 8'(p == 5 ? 2 : p < 3));
        end
        exec(12'h004, 8'h00);
        chk({7'h0, xfr_valid}, 8'h00);
        rw(1'b1, REG_SELECTOR, 8'h1f);
        rw(1'b0, REG_SELECTOR, 8'h1f);
        rw(1'b0, REG_OPTION, 8'h3f);
        rw(1'b0, 4'hf, 8'h00);
        // Last transfer: exchange, other kind, port A; index 2 is read only
        rw(1'b1, REG_LAST_XFR, 8'hff);
        rw(1'b0, REG_LAST_XFR, 8'h40);
        rw(1'b1, REG_OPTION, 8'h81);
        rw(1'b0, REG_OPTION, 8'h81);
        // Mid-run reset returns both registers to zero
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        #1;
        chk(selector, SELECTOR_RST);
        chk(option, OPTION_RST);
        summarize();
    end
endmodule
